// ===== hdl/pwr_ctrl_pkg.sv
// Purpose: constants, types and helpers shared by the power mode controller
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: legal dual clock mode sequence is encoded by mode_index
package pwr_ctrl_pkg;

    // timing
    localparam int INSTR_DIV = 5;
    localparam int ENTRY_PHASE = 2;
    localparam int WAKE_START = 256;
    localparam int TIMER_W = 17;
    localparam int TAP_BASE = 12;
    localparam logic [2:0] TAP_SEL_MAX = 3'h4;

    // register byte offsets (low address byte)
    localparam logic [7:0] OFF_PORT_DATA = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_INT_CTRL = 8'h08;
    localparam logic [7:0] OFF_OPTION = 8'h0C;

    // field positions
    localparam int PD_HALT_BIT = 7;
    localparam int PD_IDLE_BIT = 6;
    localparam int PD_PLAIN_W = 6;
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_NIB_LSB = 4;
    localparam int IC_EN_BIT = 0;
    localparam int IC_PND_BIT = 1;
    localparam int OPT_HALT_DIS_BIT = 0;
    localparam int OPT_WAKE_DLY_BIT = 1;
    localparam int OPT_T2_FAST_BIT = 2;
    localparam int OPT_T2_IDLE_BIT = 3;
    localparam int OPT_STATE_LSB = 4;

    // reset values
    localparam logic [5:0] PORT_RST = 6'h00;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [3:0] OPT_RST = 4'h0;

    typedef struct packed {
        logic slow_osc_enable;
        logic fast_osc_enable;
        logic idle_timer_slow_select;
        logic core_slow_clock_select;
    } mode_bits_t;

    localparam mode_bits_t MODE_HS = 4'h4;
    localparam mode_bits_t MODE_HS_DC = 4'hC;
    localparam mode_bits_t MODE_DC = 4'hE;
    localparam mode_bits_t MODE_DC_LS = 4'hF;
    localparam mode_bits_t MODE_LS = 4'hB;
    localparam logic [2:0] MODE_BAD = 3'h7;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_IDLE = 2'b01,
        ST_HALT = 2'b10,
        ST_WAKE = 2'b11
    } pwr_state_t;

    // position of a mode value in the legal sequence, MODE_BAD otherwise
    function automatic logic [2:0] mode_index(input mode_bits_t m);
        logic [2:0] idx;
        idx = MODE_BAD;
        case (m)
            MODE_HS: idx = 3'h0;
            MODE_HS_DC: idx = 3'h1;
            MODE_DC: idx = 3'h2;
            MODE_DC_LS: idx = 3'h3;
            MODE_LS: idx = 3'h4;
            default: idx = MODE_BAD;
        endcase
        return idx;
    endfunction

endpackage

// ===== hdl/power_mode_idle_timer_ctrl.sv
// Purpose: HALT/IDLE entry and exit, wake-up start-up delay, idle timer and clock modes
// Assumes: core_clk_i stands for the high-speed oscillator; pins are asynchronous
// Notes: registers on AHB-Lite, zero wait states, always OKAY
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pwr_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// Function
// - wake-up loads idle timer with 256, counts instruction cycles, clocks resume when the count reaches zero
// - start-up delay is applied on every wake-up, whatever the delay option says
// - start-up count advances only while oscillator amplitude is qualified
// - writing 1 to port data bit 7 halts partway through the next instruction cycle
// - with the halt-disable option set, halt requests are ignored
// - writing 1 to port data bit 6 idles; oscillator and timer keep running, timer2 only with its idle option set
// - in high speed mode the idle timer runs freely at instruction rate
// - window select picks a 4k, 8k, 16k, 32k or 64k cycle tap
// - each tap toggle sets pending, raises enabled interrupt and ends idle
// - idle exit resumes at an instruction boundary so interrupt follows that instruction
// - idle also ends on reset or a multi-input wake-up event
// - reset clears the window select; the timer count is not initialised
// - interrupt enable gates the interrupt only; pending is set regardless
// - dual clock halt stops fast clock, keeps slow oscillator, timer not clocked
// - external reset during dual clock halt returns to high speed mode
// - start-up count uses the instruction clock; afterwards the timer goes back to slow clock
// - dual clock idle counts the timer on the slow clock, resumes on fast clock
// - only the listed mode bit sequence is legal; anything else resets the device
// - timer slow select 0 with core slow select 1 forces low speed mode
module power_mode_idle_timer_ctrl
    import pwr_ctrl_pkg::*;
#(
    parameter int TIMER_BITS = pwr_ctrl_pkg::TIMER_W
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // asynchronous pins
    input wire logic wake_event_i,
    input wire logic osc_amp_ok_i,
    input wire logic slow_osc_clk_i,
    // clock and power controls
    output logic core_clk_en_o,
    output logic fast_osc_run_o,
    output logic slow_osc_run_o,
    output logic core_slow_sel_o,
    output logic idle_timer_slow_o,
    output logic timer2_run_o,
    output logic idle_tick_irq_o,
    output logic self_reset_o
);
    import pwr_ctrl_pkg::*;

    logic [2:0] pins_s;
    logic wake_s;
    logic amp_ok_s;
    logic slow_s;

    pwr_sync2 #(.W(3)) u_sync (
        .clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .d_i({wake_event_i, osc_amp_ok_i, slow_osc_clk_i}),
        .q_o(pins_s)
    );
    assign wake_s = pins_s[2];
    assign amp_ok_s = pins_s[1];
    assign slow_s = pins_s[0];

    pwr_state_t state_r, state_nxt;
    mode_bits_t mode_r, mode_nxt;
    logic [2:0] sel_r, sel_nxt;
    logic [3:0] opt_r, opt_nxt;
    logic [5:0] port_r, port_nxt;
    logic irq_en_r, irq_en_nxt;
    logic pending_r, pending_nxt;
    logic halt_req_r, halt_req_nxt;
    logic idle_req_r, idle_req_nxt;
    logic idle_exit_r, idle_exit_nxt;
    logic [2:0] presc_r, presc_nxt;
    logic [TIMER_BITS-1:0] timer_r, timer_nxt;
    logic tap_prev_r, tap_prev_nxt;
    logic slow_prev_r, slow_prev_nxt;
    logic dp_write_r, dp_write_nxt;
    logic [7:0] dp_addr_r, dp_addr_nxt;
    logic [31:0] hrdata_nxt;
    logic core_en_nxt, fast_run_nxt, t2_run_nxt, irq_nxt, self_rst_nxt;

    logic instr_tick, slow_tick, timer_tick, tap_bit, tap_event, ap_valid;
    logic [2:0] sel_eff;
    logic [2:0] idx_new, idx_old;
    mode_bits_t mode_wr;
    logic forced_ls;
    logic [7:0] wb;

    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        sel_nxt = sel_r;
        opt_nxt = opt_r;
        port_nxt = port_r;
        irq_en_nxt = irq_en_r;
        pending_nxt = pending_r;
        halt_req_nxt = halt_req_r;
        idle_req_nxt = idle_req_r;
        idle_exit_nxt = idle_exit_r;
        self_rst_nxt = 1'b0;
        wb = hwdata_i[7:0];
        mode_wr = wb[MODE_NIB_LSB +: 4];
        forced_ls = 1'b0;
        idx_new = MODE_BAD;
        idx_old = mode_index(mode_r);
        hrdata_nxt = 32'h0000_0000;

        // fast oscillator is stopped in halt, so the prescaler freezes there
        instr_tick = (presc_r == 3'(INSTR_DIV - 1));
        if (state_r == ST_HALT) begin
            presc_nxt = presc_r;
        end else if (instr_tick) begin
            presc_nxt = 3'h0;
        end else begin
            presc_nxt = presc_r + 3'h1;
        end

        slow_tick = slow_s & ~slow_prev_r;
        slow_prev_nxt = slow_s;

        if (state_r == ST_WAKE) begin
            timer_tick = instr_tick & amp_ok_s;
        end else if (state_r == ST_HALT) begin
            timer_tick = 1'b0;
        end else if (mode_r.idle_timer_slow_select) begin
            timer_tick = slow_tick;
        end else begin
            timer_tick = instr_tick;
        end

        if ((state_r == ST_HALT) && wake_s) begin
            timer_nxt = TIMER_BITS'(WAKE_START);
        end else if (timer_tick) begin
            timer_nxt = timer_r - 1'b1;
        end else begin
            timer_nxt = timer_r;
        end

        // selections above the last tap read as the 64k tap
        sel_eff = (sel_r > TAP_SEL_MAX) ? TAP_SEL_MAX : sel_r;
        tap_bit = timer_r[TAP_BASE + int'(sel_eff)];
        tap_prev_nxt = tap_bit;
        // the start-up reload would fake a toggle, so taps are ignored then
        tap_event = (tap_bit != tap_prev_r) && (state_r != ST_WAKE) && (state_r != ST_HALT);

        // register writes in the data phase
        if (dp_write_r) begin
            case (dp_addr_r)
                OFF_PORT_DATA: begin
                    port_nxt = wb[PD_PLAIN_W-1:0];
                    if (wb[PD_HALT_BIT] && !opt_r[OPT_HALT_DIS_BIT]) begin
                        halt_req_nxt = 1'b1;
                    end else if (wb[PD_IDLE_BIT]) begin
                        idle_req_nxt = 1'b1;
                    end
                end
                OFF_MODE: begin
                    sel_nxt = wb[MODE_SEL_LSB +: 3];
                    if (!mode_wr.idle_timer_slow_select && mode_wr.core_slow_clock_select) begin
                        mode_wr = MODE_LS;
                        forced_ls = 1'b1;
                    end
                    idx_new = mode_index(mode_wr);
                    if ((idx_new != MODE_BAD) && (forced_ls || (idx_new == idx_old) ||
                        (idx_new == idx_old + 3'h1) || (idx_old == idx_new + 3'h1))) begin
                        mode_nxt = mode_wr;
                    end else begin
                        self_rst_nxt = 1'b1;
                    end
                end
                OFF_INT_CTRL: begin
                    irq_en_nxt = wb[IC_EN_BIT];
                    pending_nxt = wb[IC_PND_BIT];
                end
                OFF_OPTION: begin
                    opt_nxt = wb[3:0];
                end
                default: begin
                end
            endcase
        end

        // hardware set wins over a software clear in the same cycle
        if (tap_event) begin
            pending_nxt = 1'b1;
        end

        case (state_r)
            ST_RUN: begin
                if (halt_req_r && (presc_r == 3'(ENTRY_PHASE))) begin
                    state_nxt = ST_HALT;
                    halt_req_nxt = 1'b0;
                end else if (idle_req_r && (presc_r == 3'(ENTRY_PHASE))) begin
                    state_nxt = ST_IDLE;
                    idle_req_nxt = 1'b0;
                    idle_exit_nxt = 1'b0;
                end
            end
            ST_IDLE: begin
                if (tap_event || wake_s) begin
                    idle_exit_nxt = 1'b1;
                end
                if ((idle_exit_r || tap_event || wake_s) && instr_tick) begin
                    state_nxt = ST_RUN;
                    idle_exit_nxt = 1'b0;
                end
            end
            ST_HALT: begin
                if (wake_s) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (timer_tick && (timer_r == TIMER_BITS'(1))) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_RUN;
        endcase

        // an illegal mode value restarts the controller in high speed mode
        if (self_rst_nxt) begin
            state_nxt = ST_RUN;
            mode_nxt = MODE_HS;
            sel_nxt = SEL_RST;
            halt_req_nxt = 1'b0;
            idle_req_nxt = 1'b0;
        end

        core_en_nxt = (state_nxt == ST_RUN);
        fast_run_nxt = mode_nxt.fast_osc_enable && (state_nxt != ST_HALT);
        t2_run_nxt = opt_nxt[OPT_T2_FAST_BIT] &&
            ((state_nxt == ST_RUN) || ((state_nxt == ST_IDLE) && opt_nxt[OPT_T2_IDLE_BIT]));
        irq_nxt = pending_nxt && irq_en_nxt;

        // address phase; read data built from next values so writes show at once
        ap_valid = hsel_i && htrans_i[1] && hready_i;
        dp_write_nxt = ap_valid && hwrite_i;
        dp_addr_nxt = haddr_i[7:0];
        if (ap_valid && !hwrite_i) begin
            case (haddr_i[7:0])
                OFF_PORT_DATA: begin
                    hrdata_nxt[PD_PLAIN_W-1:0] = port_nxt;
                    hrdata_nxt[PD_IDLE_BIT] = (state_nxt == ST_IDLE) || idle_req_nxt;
                    hrdata_nxt[PD_HALT_BIT] = (state_nxt == ST_HALT) || halt_req_nxt;
                end
                OFF_MODE: begin
                    hrdata_nxt[MODE_SEL_LSB +: 3] = sel_nxt;
                    hrdata_nxt[MODE_NIB_LSB +: 4] = mode_nxt;
                end
                OFF_INT_CTRL: begin
                    hrdata_nxt[IC_EN_BIT] = irq_en_nxt;
                    hrdata_nxt[IC_PND_BIT] = pending_nxt;
                end
                OFF_OPTION: begin
                    hrdata_nxt[3:0] = opt_nxt;
                    hrdata_nxt[OPT_STATE_LSB +: 2] = state_nxt;
                end
                default: hrdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // the idle timer count has no reset value, like the real free-running counter
    always_ff @(posedge core_clk_i) begin
        timer_r <= timer_nxt;
        tap_prev_r <= tap_prev_nxt;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= ST_RUN;
            mode_r <= MODE_HS;
            sel_r <= SEL_RST;
            opt_r <= OPT_RST;
            port_r <= PORT_RST;
            irq_en_r <= 1'b0;
            pending_r <= 1'b0;
            halt_req_r <= 1'b0;
            idle_req_r <= 1'b0;
            idle_exit_r <= 1'b0;
            presc_r <= 3'h0;
            slow_prev_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            core_clk_en_o <= 1'b1;
            fast_osc_run_o <= 1'b1;
            slow_osc_run_o <= 1'b0;
            core_slow_sel_o <= 1'b0;
            idle_timer_slow_o <= 1'b0;
            timer2_run_o <= 1'b0;
            idle_tick_irq_o <= 1'b0;
            self_reset_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            sel_r <= sel_nxt;
            opt_r <= opt_nxt;
            port_r <= port_nxt;
            irq_en_r <= irq_en_nxt;
            pending_r <= pending_nxt;
            halt_req_r <= halt_req_nxt;
            idle_req_r <= idle_req_nxt;
            idle_exit_r <= idle_exit_nxt;
            presc_r <= presc_nxt;
            slow_prev_r <= slow_prev_nxt;
            dp_write_r <= dp_write_nxt;
            dp_addr_r <= dp_addr_nxt;
            hrdata_o <= hrdata_nxt;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            core_clk_en_o <= core_en_nxt;
            fast_osc_run_o <= fast_run_nxt;
            slow_osc_run_o <= mode_nxt.slow_osc_enable;
            core_slow_sel_o <= mode_nxt.core_slow_clock_select;
            idle_timer_slow_o <= mode_nxt.idle_timer_slow_select;
            timer2_run_o <= t2_run_nxt;
            idle_tick_irq_o <= irq_nxt;
            self_reset_o <= self_rst_nxt;
        end
    end

endmodule

`default_nettype wire

// ===== test/pwr_ctrl_monitor.sv
// Purpose: port-level assertions for the power mode controller
// Assumes: bound to the controller top, one clock domain
// Notes: register contents are hidden, so bus writes are decoded here
`timescale 1ns/1ps
`default_nettype none
module pwr_ctrl_monitor
    import pwr_ctrl_pkg::*;
#(
    parameter int TIMER_BITS = TIMER_W
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // power controls
    input wire logic core_clk_en_o,
    input wire logic fast_osc_run_o,
    input wire logic slow_osc_run_o,
    input wire logic core_slow_sel_o,
    input wire logic idle_timer_slow_o,
    input wire logic idle_tick_irq_o,
    input wire logic self_reset_o
);
    localparam int WAKE_MIN = WAKE_START * INSTR_DIV - INSTR_DIV;
    logic take, wr_port_r, wr_mode_r, halted_r, bad_nib;
    logic [3:0] req_age_r;
    logic [15:0] wake_cnt_r;
    assign take = hsel_i && htrans_i[1] && hready_i;
    assign bad_nib = !(hwdata_i[7:4] inside {4'hB, 4'h4, 4'hC, 4'hE, 4'hF}) && hwdata_i[5:4] != 2'h1;
    // halted_r covers halt and the wake delay; idle in low speed mode, with the fast oscillator off, is taken for it too
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_port_r <= 1'b0;
            wr_mode_r <= 1'b0;
            halted_r <= 1'b0;
            req_age_r <= 4'hF;
            wake_cnt_r <= 16'h0;
        end else begin
            wr_port_r <= take && hwrite_i && haddr_i[7:0] == OFF_PORT_DATA;
            wr_mode_r <= take && hwrite_i && haddr_i[7:0] == OFF_MODE;
            halted_r <= !core_clk_en_o && (halted_r || !fast_osc_run_o);
            wake_cnt_r <= (halted_r && fast_osc_run_o) ? wake_cnt_r + 16'h1 : 16'h0;
            if (wr_port_r && |hwdata_i[7:6]) begin
                req_age_r <= 4'h0;
            end else if (req_age_r != 4'hF) begin
                req_age_r <= req_age_r + 4'h1;
            end
        end
    end
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_pulse;
        self_reset_o ##1 !self_reset_o;
    endsequence
    sequence s_home;
        fast_osc_run_o && !slow_osc_run_o && !core_slow_sel_o && !idle_timer_slow_o;
    endsequence
    chk_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    chk_unmapped_zero: assert property (take && !hwrite_i && haddr_i[7:0] > OFF_OPTION
        |=> hrdata_o == 32'h0) else $error("unmapped read not zero");
    chk_upper_zero: assert property (take && !hwrite_i |=> hrdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_wake_min: assert property ($rose(core_clk_en_o) && halted_r && fast_osc_run_o
        |-> wake_cnt_r >= WAKE_MIN) else $error("core clocks back before start-up delay");
    chk_stop_cause: assert property ($fell(core_clk_en_o) |-> req_age_r <= 4'hA)
        else $error("core clocks stopped without a request");
    chk_self_pulse: assert property (self_reset_o |-> s_pulse)
        else $error("self reset longer than one cycle");
    chk_bad_mode: assert property (wr_mode_r && bad_nib |-> ##[1:4] s_pulse ##[0:3] s_home)
        else $error("illegal mode value did not reset");
    chk_force_low: assert property (wr_mode_r && hwdata_i[5:4] == 2'h1
        |-> ##[1:4] (core_slow_sel_o && idle_timer_slow_o && slow_osc_run_o && !fast_osc_run_o))
        else $error("low speed mode not forced");
    chk_irq_ends_idle: assert property ($rose(idle_tick_irq_o) && !core_clk_en_o &&
        fast_osc_run_o && !halted_r |-> ##[0:12] core_clk_en_o) else $error("idle not ended");
    chk_dc_halt_slow: assert property (!core_clk_en_o && !fast_osc_run_o && idle_timer_slow_o
        |-> slow_osc_run_o) else $error("slow oscillator stopped in halt");
endmodule
`default_nettype wire

// ===== test/power_mode_idle_timer_ctrl_bench.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: zero-wait bus slave, hsize fixed to a word
// Notes: one 4k idle window is about 20k clocks, so only window 0 is timed
`timescale 1ns/1ps
`default_nettype none
module power_mode_idle_timer_ctrl_bench;
    import pwr_ctrl_pkg::*;
    logic core_clk_i = 1'b0, rst_b_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, irq_d = 1'b0;
    logic wake_event_i = 1'b0, osc_amp_ok_i = 1'b1, slow_osc_clk_i = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, q;
    logic [1:0] htrans_i = 2'h0;
    logic hreadyout_o, hresp_o, core_clk_en_o, fast_osc_run_o, slow_osc_run_o, core_slow_sel_o;
    logic idle_timer_slow_o, timer2_run_o, idle_tick_irq_o, self_reset_o;
    int err_count = 0, comparisons = 0, gap = 0, last_gap = 0, pulses = 0, n;

    power_mode_idle_timer_ctrl #(.TIMER_BITS(TIMER_W)) power_mode_idle_timer_ctrl_inst (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .wake_event_i(wake_event_i), .osc_amp_ok_i(osc_amp_ok_i),
        .slow_osc_clk_i(slow_osc_clk_i), .core_clk_en_o(core_clk_en_o),
        .fast_osc_run_o(fast_osc_run_o), .slow_osc_run_o(slow_osc_run_o),
        .core_slow_sel_o(core_slow_sel_o), .idle_timer_slow_o(idle_timer_slow_o),
        .timer2_run_o(timer2_run_o), .idle_tick_irq_o(idle_tick_irq_o),
        .self_reset_o(self_reset_o)
    );

    initial forever #4 core_clk_i = ~core_clk_i;
    // slow oscillator is unrelated to the core clock on purpose
    initial forever #163 slow_osc_clk_i = ~slow_osc_clk_i;

    always @(negedge core_clk_i) begin
        if (idle_tick_irq_o === 1'b1 && !irq_d) begin
            last_gap = gap;
            gap = 1;
        end else begin
            gap++;
        end
        irq_d = (idle_tick_irq_o === 1'b1);
        if (self_reset_o === 1'b1) pulses++;
    end

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hang;
        err_count++;
        $display("FAIL wait expected answer seen none");
        close_out();
    endtask

    // master holds each phase until hready is seen high at a falling edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= {24'h00_0000, a};
        hwrite_i <= wr;
        do begin
            @(negedge core_clk_i);
            k++;
        end while (hreadyout_o !== 1'b1 && k < 20);
        @(posedge core_clk_i);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do begin
            @(negedge core_clk_i);
            k++;
            q = hrdata_o;
        end while (hreadyout_o !== 1'b1 && k < 40);
        @(posedge core_clk_i);
        if (k >= 40) hang();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, exp, q);
    endtask

    // order: clock enable, fast, slow, core slow, timer slow, timer2, irq
    task automatic pins(input logic [6:0] exp);
        repeat (3) @(negedge core_clk_i);
        check("pins", {25'h0, exp}, {25'h0, core_clk_en_o, fast_osc_run_o, slow_osc_run_o,
            core_slow_sel_o, idle_timer_slow_o, timer2_run_o, idle_tick_irq_o});
    endtask

    task automatic wait_pin(input logic irq, input logic lvl, input int lim);
        n = 0;
        do begin
            @(negedge core_clk_i);
            n++;
        end while ((irq ? idle_tick_irq_o : core_clk_en_o) !== lvl && n < lim);
        if (n >= lim) hang();
    endtask

    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        rd("mode", OFF_MODE, 32'h0000_0040);
        rd("option", OFF_OPTION, 32'h0000_0000);
        rd("unmapped", 8'h10, 32'h0000_0000);
        pins(7'h60);
        wr(OFF_PORT_DATA, 32'h0000_0015);
        rd("port", OFF_PORT_DATA, 32'h0000_0015);
        // halt, then wake with the oscillator not yet qualified
        osc_amp_ok_i <= 1'b0;
        wr(OFF_OPTION, 32'h0000_0006);
        pins(7'h62);
        wr(OFF_PORT_DATA, 32'h0000_0080);
        wait_pin(1'b0, 1'b0, 20);
        rd("halt state", OFF_OPTION, 32'h0000_0026);
        pins(7'h00);
        @(posedge core_clk_i);
        wake_event_i <= 1'b1;
        repeat (400) @(posedge core_clk_i);
        rd("wake state", OFF_OPTION, 32'h0000_0036);
        @(posedge core_clk_i);
        osc_amp_ok_i <= 1'b1;
        wake_event_i <= 1'b0;
        wait_pin(1'b0, 1'b1, 2000);
        check("wake delay", 32'h1, 32'(n >= 1270 && n <= 1300));
        wr(OFF_OPTION, 32'h0000_0001);
        wr(OFF_PORT_DATA, 32'h0000_0080);
        repeat (20) @(posedge core_clk_i);
        rd("halt refused", OFF_OPTION, 32'h0000_0001);
        pins(7'h60);
        // idle without the interrupt: pending still sets
        wr(OFF_OPTION, 32'h0000_0004);
        wr(OFF_INT_CTRL, 32'h0000_0000);
        wr(OFF_PORT_DATA, 32'h0000_0040);
        wait_pin(1'b0, 1'b0, 20);
        rd("idle state", OFF_OPTION, 32'h0000_0014);
        pins(7'h20);
        wait_pin(1'b0, 1'b1, 20700);
        rd("pending", OFF_INT_CTRL, 32'h0000_0002);
        pins(7'h62);
        wr(OFF_INT_CTRL, 32'h0000_0001);
        wait_pin(1'b1, 1'b1, 20700);
        wr(OFF_INT_CTRL, 32'h0000_0001);
        wait_pin(1'b1, 1'b1, 20700);
        wr(OFF_INT_CTRL, 32'h0000_0001);
        check("window", 32'((1 << TAP_BASE) * INSTR_DIV), 32'(last_gap));
        wr(OFF_PORT_DATA, 32'h0000_0040);
        wait_pin(1'b0, 1'b0, 20);
        wait_pin(1'b0, 1'b1, 20700);
        pins(7'h63);
        // idle ended by a wake-up event, timer2 kept running in idle
        wr(OFF_INT_CTRL, 32'h0000_0000);
        wr(OFF_OPTION, 32'h0000_000C);
        wr(OFF_PORT_DATA, 32'h0000_0040);
        wait_pin(1'b0, 1'b0, 20);
        pins(7'h22);
        @(posedge core_clk_i);
        wake_event_i <= 1'b1;
        wait_pin(1'b0, 1'b1, 20);
        @(posedge core_clk_i);
        wake_event_i <= 1'b0;
        rd("run state", OFF_OPTION, 32'h0000_000C);
        // clock modes
        wr(OFF_MODE, 32'h0000_00C0);
        repeat (50) @(posedge core_clk_i);
        pins(7'h72);
        wr(OFF_MODE, 32'h0000_00E0);
        pins(7'h76);
        // interrupt is already masked while the window select changes
        wr(OFF_MODE, 32'h0000_0014);
        rd("forced low", OFF_MODE, 32'h0000_00B4);
        pins(7'h5E);
        wr(OFF_INT_CTRL, 32'h0000_0000);
        wr(OFF_MODE, 32'h0000_00F4);
        repeat (50) @(posedge core_clk_i);
        wr(OFF_MODE, 32'h0000_00E4);
        pins(7'h76);
        wr(OFF_MODE, 32'h0000_0020);
        rd("mode home", OFF_MODE, 32'h0000_0040);
        check("self resets", 32'h1, 32'(pulses));
        wr(OFF_MODE, 32'h0000_00C0);
        wr(OFF_MODE, 32'h0000_00E0);
        wr(OFF_PORT_DATA, 32'h0000_0080);
        wait_pin(1'b0, 1'b0, 20);
        pins(7'h14);
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        rd("mode after reset", OFF_MODE, 32'h0000_0040);
        pins(7'h60);
        close_out();
    end
endmodule

bind power_mode_idle_timer_ctrl pwr_ctrl_monitor #(.TIMER_BITS(TIMER_BITS)) pwr_ctrl_monitor_inst (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .core_clk_en_o(core_clk_en_o), .fast_osc_run_o(fast_osc_run_o),
    .slow_osc_run_o(slow_osc_run_o), .core_slow_sel_o(core_slow_sel_o),
    .idle_timer_slow_o(idle_timer_slow_o), .idle_tick_irq_o(idle_tick_irq_o),
    .self_reset_o(self_reset_o)
);
`default_nettype wire
